// >>> logic/asr_pkg.sv
// constants for the two-axis status readout block
// assumes one 10 MHz system clock shared with the requesting logic
package asr_pkg;

    // ------------------------------------------------------------
    // axis selection and answer codes
    // ------------------------------------------------------------
    localparam int AXIS_COUNT = 2;
    localparam logic [7:0] AXIS_X = 8'h00;
    localparam logic [7:0] AXIS_Y = 8'h01;
    localparam logic [15:0] STAT_OK = 16'h0000;
    localparam logic [15:0] STAT_BAD_AXIS = 16'h0006;

    // ------------------------------------------------------------
    // group 1: run state
    // ------------------------------------------------------------
    localparam int G1_BUSY = 0;
    localparam int G1_ERROR = 1;
    localparam int G1_POS_DONE = 2;
    localparam int G1_AUX_ON = 3;
    localparam int G1_ORIGIN = 4;
    localparam int G1_STOP = 6;

    // ------------------------------------------------------------
    // group 2: limits, direction and speed phase
    // ------------------------------------------------------------
    localparam int G2_LIMIT_HI = 0;
    localparam int G2_LIMIT_LO = 1;
    localparam int G2_ESTOP = 2;
    localparam int G2_REVERSE = 3;
    localparam int G2_ACCEL = 4;
    localparam int G2_CONST = 5;
    localparam int G2_DECEL = 6;
    localparam int G2_DWELL = 7;

    // ------------------------------------------------------------
    // group 3: control mode, group 4: manual operation
    // ------------------------------------------------------------
    localparam int G3_POSITION = 0;
    localparam int G3_SPEED = 1;
    localparam int G3_LINEAR = 2;
    localparam int G3_CIRCULAR = 4;
    localparam int G3_HOMING = 5;
    localparam int G3_POS_SYNC = 6;
    localparam int G3_SPD_SYNC = 7;
    localparam int G4_JOG_LOW = 0;
    localparam int G4_JOG_HIGH = 1;
    localparam int G4_INCHING = 2;

    // ------------------------------------------------------------
    // group 5: main-axis source and role
    // ------------------------------------------------------------
    localparam logic [1:0] FOLLOW_NONE = 2'h0;
    localparam logic [1:0] FOLLOW_X = 2'h1;
    localparam logic [1:0] FOLLOW_Y = 2'h2;
    localparam logic [1:0] FOLLOW_ENC = 2'h3;
    localparam logic [2:0] SRC_CODE_NONE = 3'h0;
    localparam logic [2:0] SRC_CODE_X = 3'h1;
    localparam logic [2:0] SRC_CODE_Y = 3'h2;
    localparam logic [2:0] SRC_CODE_ENC = 3'h4;
    localparam int G5_SRC_LSB = 0;
    localparam int G5_ROLE = 3;

    // ------------------------------------------------------------
    // groups 6 and 7: external signals
    // ------------------------------------------------------------
    localparam int G6_LIMIT_HI = 4;
    localparam int G6_LIMIT_LO = 5;
    localparam int G6_ORIGIN = 6;
    localparam int G6_DOG = 7;
    localparam int G7_IN_POS = 4;
    localparam int G7_DEV_CLEAR = 5;

endpackage

// >>> logic/asr_sync.sv
// two-stage synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module asr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = pin_async;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_sync = sync_q;
endmodule // asr_sync

// >>> logic/asr_readout.sv
// status readout for a two-axis pulse-train positioning module
// assumes requests and axis state come from logic on sys_clk; limit,
// origin, dog and in-position pins are asynchronous
//
// What this block does
// - info read returns error code, position, speed, step and aux code of axis.
// - axis 0 is X, 1 is Y; other values make info and state-bit reads report error 6, no data.
// - completion indication stays 1 once a request has first completed.
// - a failed read puts its error number on the status output.
// - group 1 holds busy, error, done, aux, origin, stop; bits 5,7 unused.
// - group 2 holds limits, emergency stop, direction and speed phase bits.
// - group 3 holds control mode bits; bit 3 unused.
// - group 4 holds jog low, jog high and inching; bits 3 to 7 unused.
// - group 5 encodes main source 1 X, 2 Y, 4 encoder; bit 3 role.
// - group 6 mirrors limit, origin, dog pins; group 7 in-position, clear.
// - state-bit read delivers seven 8-bit groups for the selected axis.
// - encoder read returns the current count as unsigned 32 bits.
// - reads refresh every cycle while request is high, hold once low.
`timescale 1ns/1ps
module asr_readout
    import asr_pkg::*;
#(
    parameter int AXES = AXIS_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic operation_info_read,
    input wire logic state_bits_read,
    input wire logic encoder_count_read,
    input wire logic [7:0] axis_sel,
    input wire logic [AXES-1:0][15:0] axis_err_code,
    input wire logic [AXES-1:0][31:0] axis_position,
    input wire logic [AXES-1:0][31:0] axis_speed,
    input wire logic [AXES-1:0][15:0] axis_step,
    input wire logic [AXES-1:0][15:0] axis_aux_code,
    input wire logic [AXES-1:0][5:0] axis_run_flags,
    input wire logic [AXES-1:0][3:0] axis_limit_flags,
    input wire logic [AXES-1:0][3:0] axis_phase,
    input wire logic [AXES-1:0][6:0] axis_ctrl_mode,
    input wire logic [AXES-1:0][2:0] axis_manual_mode,
    input wire logic [AXES-1:0][1:0] axis_follow_src,
    input wire logic [AXES-1:0] axis_is_sub,
    input wire logic [AXES-1:0] dev_clear_out,
    input wire logic [AXES-1:0] limit_hi_pin,
    input wire logic [AXES-1:0] limit_lo_pin,
    input wire logic [AXES-1:0] origin_pin,
    input wire logic [AXES-1:0] dog_pin,
    input wire logic [AXES-1:0] in_pos_pin,
    input wire logic [31:0] enc_live_count,
    output logic info_done,
    output logic [15:0] info_stat,
    output logic [15:0] info_err_code,
    output logic signed [31:0] current_position,
    output logic [31:0] current_speed,
    output logic [15:0] info_step,
    output logic [15:0] aux_code_value,
    output logic bits_done,
    output logic [15:0] bits_stat,
    output logic [7:0] status_group_1,
    output logic [7:0] status_group_2,
    output logic [7:0] status_group_3,
    output logic [7:0] status_group_4,
    output logic [7:0] status_group_5,
    output logic [7:0] status_group_6,
    output logic [7:0] status_group_7,
    output logic enc_done,
    output logic [15:0] enc_stat,
    output logic [31:0] encoder_count
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5*AXES-1:0] pins_s;
    logic [AXES-1:0] lim_hi_s;
    logic [AXES-1:0] lim_lo_s;
    logic [AXES-1:0] origin_s;
    logic [AXES-1:0] dog_s;
    logic [AXES-1:0] in_pos_s;

    asr_sync #(.WIDTH(5*AXES)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_async({in_pos_pin, dog_pin, origin_pin, limit_lo_pin, limit_hi_pin}),
        .pin_sync(pins_s)
    );
    assign {in_pos_s, dog_s, origin_s, lim_lo_s, lim_hi_s} = pins_s;

    // ------------------------------------------------------------
    // axis selection
    // ------------------------------------------------------------
    logic axis_ok;
    logic sel;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [7:0] g3;
    logic [7:0] g4;
    logic [7:0] g5;
    logic [7:0] g6;
    logic [7:0] g7;
    logic [2:0] src_code;

    assign axis_ok = (axis_sel == AXIS_X) || (axis_sel == AXIS_Y);
    assign sel = axis_sel[0];

    // ------------------------------------------------------------
    // status group assembly; unlisted bits stay zero
    // ------------------------------------------------------------
    always_comb begin
        g1 = 8'h00;
        g2 = 8'h00;
        g3 = 8'h00;
        g4 = 8'h00;
        g5 = 8'h00;
        g6 = 8'h00;
        g7 = 8'h00;
        g1[G1_BUSY] = axis_run_flags[sel][0];
        g1[G1_ERROR] = axis_run_flags[sel][1];
        g1[G1_POS_DONE] = axis_run_flags[sel][2];
        g1[G1_AUX_ON] = axis_run_flags[sel][3];
        g1[G1_ORIGIN] = axis_run_flags[sel][4];
        g1[G1_STOP] = axis_run_flags[sel][5];
        g2[G2_LIMIT_HI] = axis_limit_flags[sel][0];
        g2[G2_LIMIT_LO] = axis_limit_flags[sel][1];
        g2[G2_ESTOP] = axis_limit_flags[sel][2];
        g2[G2_REVERSE] = axis_limit_flags[sel][3];
        g2[G2_ACCEL] = axis_phase[sel][0];
        g2[G2_CONST] = axis_phase[sel][1];
        g2[G2_DECEL] = axis_phase[sel][2];
        g2[G2_DWELL] = axis_phase[sel][3];
        g3[G3_POSITION] = axis_ctrl_mode[sel][0];
        g3[G3_SPEED] = axis_ctrl_mode[sel][1];
        g3[G3_LINEAR] = axis_ctrl_mode[sel][2];
        g3[G3_CIRCULAR] = axis_ctrl_mode[sel][3];
        g3[G3_HOMING] = axis_ctrl_mode[sel][4];
        g3[G3_POS_SYNC] = axis_ctrl_mode[sel][5];
        g3[G3_SPD_SYNC] = axis_ctrl_mode[sel][6];
        g4[G4_JOG_LOW] = axis_manual_mode[sel][0];
        g4[G4_JOG_HIGH] = axis_manual_mode[sel][1];
        g4[G4_INCHING] = axis_manual_mode[sel][2];
        case (axis_follow_src[sel])
            FOLLOW_X: src_code = SRC_CODE_X;
            FOLLOW_Y: src_code = SRC_CODE_Y;
            FOLLOW_ENC: src_code = SRC_CODE_ENC;
            default: src_code = SRC_CODE_NONE;
        endcase
        g5[G5_SRC_LSB +: 3] = src_code;
        g5[G5_ROLE] = axis_is_sub[sel];
        g6[G6_LIMIT_HI] = lim_hi_s[sel];
        g6[G6_LIMIT_LO] = lim_lo_s[sel];
        g6[G6_ORIGIN] = origin_s[sel];
        g6[G6_DOG] = dog_s[sel];
        g7[G7_IN_POS] = in_pos_s[sel];
        g7[G7_DEV_CLEAR] = dev_clear_out[sel];
    end

    // ------------------------------------------------------------
    // answer registers
    // ------------------------------------------------------------
    logic info_done_q, info_done_d, bits_done_q, bits_done_d, enc_done_q, enc_done_d;
    logic [15:0] info_stat_q, info_stat_d, bits_stat_q, bits_stat_d, enc_stat_q, enc_stat_d;
    logic [15:0] err_q, err_d, step_q, step_d, aux_q, aux_d;
    logic [31:0] pos_q, pos_d, spd_q, spd_d, enc_q, enc_d;
    logic [6:0][7:0] grp_q;
    logic [6:0][7:0] grp_d;

    always_comb begin
        info_done_d = info_done_q;
        info_stat_d = info_stat_q;
        err_d = err_q;
        pos_d = pos_q;
        spd_d = spd_q;
        step_d = step_q;
        aux_d = aux_q;
        bits_done_d = bits_done_q;
        bits_stat_d = bits_stat_q;
        grp_d = grp_q;
        enc_done_d = enc_done_q;
        enc_stat_d = enc_stat_q;
        enc_d = enc_q;
        if (operation_info_read) begin
            info_done_d = 1'b1;
            if (axis_ok) begin
                info_stat_d = STAT_OK;
                err_d = axis_err_code[sel];
                pos_d = axis_position[sel];
                spd_d = axis_speed[sel];
                step_d = axis_step[sel];
                aux_d = axis_aux_code[sel];
            end else begin
                info_stat_d = STAT_BAD_AXIS;
            end
        end
        if (state_bits_read) begin
            bits_done_d = 1'b1;
            if (axis_ok) begin
                bits_stat_d = STAT_OK;
                grp_d = {g7, g6, g5, g4, g3, g2, g1};
            end else begin
                bits_stat_d = STAT_BAD_AXIS;
            end
        end
        if (encoder_count_read) begin
            enc_done_d = 1'b1;
            enc_stat_d = STAT_OK;
            enc_d = enc_live_count;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            info_done_q <= 1'b0;
            info_stat_q <= STAT_OK;
            err_q <= 16'h0000;
            pos_q <= 32'h0000_0000;
            spd_q <= 32'h0000_0000;
            step_q <= 16'h0000;
            aux_q <= 16'h0000;
            bits_done_q <= 1'b0;
            bits_stat_q <= STAT_OK;
            grp_q <= '0;
            enc_done_q <= 1'b0;
            enc_stat_q <= STAT_OK;
            enc_q <= 32'h0000_0000;
        end else begin
            info_done_q <= info_done_d;
            info_stat_q <= info_stat_d;
            err_q <= err_d;
            pos_q <= pos_d;
            spd_q <= spd_d;
            step_q <= step_d;
            aux_q <= aux_d;
            bits_done_q <= bits_done_d;
            bits_stat_q <= bits_stat_d;
            grp_q <= grp_d;
            enc_done_q <= enc_done_d;
            enc_stat_q <= enc_stat_d;
            enc_q <= enc_d;
        end
    end

    assign info_done = info_done_q;
    assign info_stat = info_stat_q;
    assign info_err_code = err_q;
    assign current_position = pos_q;
    assign current_speed = spd_q;
    assign info_step = step_q;
    assign aux_code_value = aux_q;
    assign bits_done = bits_done_q;
    assign bits_stat = bits_stat_q;
    assign {status_group_7, status_group_6, status_group_5, status_group_4,
            status_group_3, status_group_2, status_group_1} = grp_q;
    assign enc_done = enc_done_q;
    assign enc_stat = enc_stat_q;
    assign encoder_count = enc_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_info_capture: assert property (operation_info_read && axis_ok |=>
        current_position == $past(axis_position[sel]) && info_stat == STAT_OK
        && aux_code_value == $past(axis_aux_code[sel]))
        else $error("info read did not capture selected axis");
    chk_bad_axis_hold: assert property (operation_info_read && !axis_ok |=>
        $stable(current_position) && $stable(current_speed))
        else $error("axis data changed on bad axis");
    chk_bad_axis_stat: assert property (state_bits_read && !axis_ok |=>
        bits_stat == STAT_BAD_AXIS && $stable(status_group_1))
        else $error("bad axis not reported as error 6");
    chk_done_sticky: assert property (info_done |=> info_done)
        else $error("completion indication dropped");
    chk_unused_zero: assert property (status_group_1[5] == 1'b0 &&
        status_group_1[7] == 1'b0 && status_group_5[7:4] == 4'h0 &&
        status_group_3[3] == 1'b0 && status_group_4[7:3] == 5'h00
        && status_group_6[3:0] == 4'h0 && status_group_7[3:0] == 4'h0)
        else $error("unused status bit set");
    chk_source_code: assert property (state_bits_read && axis_ok &&
        axis_follow_src[sel] == FOLLOW_ENC |=> status_group_5[2:0] == 3'h4)
        else $error("encoder source not coded as 4");
    chk_pin_mirror: assert property (state_bits_read && axis_ok |=>
        status_group_6[G6_DOG] == $past(dog_s[sel])
        && status_group_7[G7_IN_POS] == $past(in_pos_s[sel]))
        else $error("pin mirror wrong");
    chk_enc_value: assert property (encoder_count_read |=>
        encoder_count == $past(enc_live_count))
        else $error("encoder count not returned");
    chk_idle_hold: assert property (!encoder_count_read && !state_bits_read |=>
        $stable(encoder_count) && $stable(status_group_2))
        else $error("output changed without request");

    cov_info_ok: cover property (operation_info_read && axis_ok ##1 info_done);
    cov_bad_axis: cover property (state_bits_read && !axis_ok ##1 bits_stat == STAT_BAD_AXIS);
    cov_enc_long: cover property (encoder_count_read [*4] ##1 !encoder_count_read);
endmodule // asr_readout

// >>> bench/asr_cpu_model.sv
// requesting controller model: raises one read request as a level for a set number of cycles
// assumes the readout block samples requests on the rising edge of sys_clk
`timescale 1ns/1ps
module asr_cpu_model (
    input wire logic sys_clk,
    output logic info_rd,
    output logic bits_rd,
    output logic enc_rd,
    output logic [7:0] axis_sel
);
    initial begin
        info_rd = 1'b0;
        bits_rd = 1'b0;
        enc_rd = 1'b0;
        axis_sel = 8'h00;
    end

    // kind 0 info, 1 state bits, 2 encoder; request holds high for all cycles given
    task automatic request(input int kind, input logic [7:0] axis, input int cycles);
        @(posedge sys_clk);
        #1;
        axis_sel = axis;
        info_rd = (kind == 0);
        bits_rd = (kind == 1);
        enc_rd = (kind == 2);
        repeat (cycles) @(posedge sys_clk);
        #1;
        info_rd = 1'b0;
        bits_rd = 1'b0;
        enc_rd = 1'b0;
        // released selection is inverted so a stale value cannot pass for a held one
        axis_sel = ~axis;
    endtask
endmodule // asr_cpu_model

// >>> bench/asr_readout_tb_top.sv
// self-checking bench for the two-axis status readout
// assumes a 10 MHz clock, active-high async reset and the controller model beside it
`timescale 1ns/1ps
module asr_readout_tb_top;
    import asr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic info_rd, bits_rd, enc_rd;
    logic [7:0] axis_sel;
    logic [1:0][15:0] err_c, step, aux;
    logic [1:0][31:0] pos, spd;
    logic [1:0][5:0] run_f;
    logic [1:0][3:0] lim_f, phase;
    logic [1:0][6:0] cmode;
    logic [1:0][2:0] mmode;
    logic [1:0][1:0] fsrc;
    logic [1:0] sub, clr, lhi, llo, org, dog, inp;
    logic [31:0] enc;
    logic info_done, bits_done, enc_done;
    logic [15:0] info_stat, info_err_code, info_step, aux_code_value, bits_stat, enc_stat;
    logic signed [31:0] current_position;
    logic [31:0] current_speed, encoder_count;
    logic [7:0] status_group_1, status_group_2, status_group_3, status_group_4;
    logic [7:0] status_group_5, status_group_6, status_group_7;
    int fails = 0;
    int total_checks = 0;

    always #50 sys_clk = ~sys_clk;

    asr_cpu_model i_asr_cpu_model (.sys_clk(sys_clk), .info_rd(info_rd), .bits_rd(bits_rd),
        .enc_rd(enc_rd), .axis_sel(axis_sel));

    asr_readout i_asr_readout (.sys_clk(sys_clk), .rst(rst), .operation_info_read(info_rd),
        .state_bits_read(bits_rd), .encoder_count_read(enc_rd), .axis_sel(axis_sel),
        .axis_err_code(err_c), .axis_position(pos), .axis_speed(spd), .axis_step(step),
        .axis_aux_code(aux), .axis_run_flags(run_f), .axis_limit_flags(lim_f),
        .axis_phase(phase), .axis_ctrl_mode(cmode), .axis_manual_mode(mmode),
        .axis_follow_src(fsrc), .axis_is_sub(sub), .dev_clear_out(clr), .limit_hi_pin(lhi),
        .limit_lo_pin(llo), .origin_pin(org), .dog_pin(dog), .in_pos_pin(inp),
        .enc_live_count(enc), .info_done(info_done), .info_stat(info_stat),
        .info_err_code(info_err_code), .current_position(current_position),
        .current_speed(current_speed), .info_step(info_step), .aux_code_value(aux_code_value),
        .bits_done(bits_done), .bits_stat(bits_stat), .status_group_1(status_group_1),
        .status_group_2(status_group_2), .status_group_3(status_group_3),
        .status_group_4(status_group_4), .status_group_5(status_group_5),
        .status_group_6(status_group_6), .status_group_7(status_group_7),
        .enc_done(enc_done), .enc_stat(enc_stat), .encoder_count(encoder_count));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // seven groups packed group 7 down to group 1
    function automatic logic [55:0] exp_groups(input int a);
        logic [2:0] code;
        code = (fsrc[a] == 2'h3) ? 3'h4 : {1'b0, fsrc[a]};
        return {2'h0, clr[a], inp[a], 4'h0, dog[a], org[a], llo[a], lhi[a], 4'h0,
            4'h0, sub[a], code, 5'h00, mmode[a], cmode[a][6:3], 1'b0, cmode[a][2:0],
            phase[a], lim_f[a], 1'b0, run_f[a][5], 1'b0, run_f[a][4:0]};
    endfunction

    function automatic logic [55:0] seen_groups();
        return {status_group_7, status_group_6, status_group_5, status_group_4,
            status_group_3, status_group_2, status_group_1};
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_info();
        for (int a = 0; a < 2; a++) begin
            i_asr_cpu_model.request(0, a[7:0], 1);
            check("info_done", info_done, 1'b1);
            check("info_stat", info_stat, STAT_OK);
            check("info_err_code", info_err_code, err_c[a]);
            check("current_position", current_position, $signed(pos[a]));
            check("current_speed", current_speed, spd[a]);
            check("info_step", info_step, step[a]);
            check("aux_code_value", aux_code_value, aux[a]);
        end
        i_asr_cpu_model.request(0, 8'h02, 1);
        check("info_stat bad", info_stat, STAT_BAD_AXIS);
        check("info_done bad", info_done, 1'b1);
        check("position held", current_position, pos[1]);
        check("speed held", current_speed, spd[1]);
    endtask

    task automatic t_level();
        fork
            i_asr_cpu_model.request(0, 8'h00, 4);
            begin
                @(posedge sys_clk);
                @(posedge sys_clk);
                #1;
                pos[0] = 32'h1234_5678;
            end
        join
        check("refresh position", current_position, 32'h1234_5678);
        check("stat back to ok", info_stat, STAT_OK);
        pos[0] = 32'h0BAD_0BAD;
        repeat (3) @(posedge sys_clk);
        #1;
        check("held position", current_position, 32'h1234_5678);
    endtask

    task automatic t_bits();
        logic [55:0] last;
        for (int f = 0; f < 4; f++) begin
            fsrc[1] = f[1:0];
            fsrc[0] = 2'(3 - f);
            sub = f[1:0];
            // pin changes need two edges through the synchroniser
            dog = dog ^ f[1:0];
            inp = inp ^ f[1:0];
            repeat (2) @(posedge sys_clk);
            for (int a = 1; a >= 0; a--) begin
                i_asr_cpu_model.request(1, a[7:0], 1);
                check("bits_done", bits_done, 1'b1);
                check("bits_stat", bits_stat, STAT_OK);
                check("groups", seen_groups(), exp_groups(a));
            end
        end
        last = exp_groups(0);
        i_asr_cpu_model.request(1, 8'hFF, 1);
        check("bits_stat bad", bits_stat, STAT_BAD_AXIS);
        check("groups held", seen_groups(), last);
    endtask

    task automatic t_enc();
        enc = 32'hFEDC_BA98;
        i_asr_cpu_model.request(2, 8'h07, 2);
        check("enc_done", enc_done, 1'b1);
        check("enc_stat", enc_stat, 16'h0000);
        check("encoder_count", encoder_count, 32'hFEDC_BA98);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    initial begin
        err_c = {16'h0006, 16'h0011};
        pos = {32'h7FFF_FFFE, 32'h8000_0001};
        spd = {32'hFFFF_FFF0, 32'h0001_0000};
        step = {16'h0002, 16'hFFFF};
        aux = {16'hA5A5, 16'h005A};
        run_f = {6'h3F, 6'h15};
        lim_f = {4'hF, 4'h5};
        phase = {4'hF, 4'hA};
        cmode = {7'h7F, 7'h2A};
        mmode = {3'h7, 3'h5};
        fsrc = {2'h0, 2'h0};
        sub = 2'h0;
        clr = 2'h2;
        lhi = 2'h3;
        llo = 2'h2;
        org = 2'h2;
        dog = 2'h1;
        inp = 2'h2;
        enc = 32'h0000_0000;
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check("done after reset", {info_done, bits_done, enc_done}, 3'h0);
        t_info();
        t_level();
        t_bits();
        t_enc();
        wrap_up();
    end
endmodule // asr_readout_tb_top
